// ### cl_pkg.sv
// Package with register map, field layouts, reset values and types of the closed-loop unit.
package cl_pkg;

	// Word addresses on the register bus (byte address = index * 4).
	localparam logic [5:0] ADDR_CONTROL = 6'h00;
	localparam logic [5:0] ADDR_STATUS = 6'h01;
	localparam logic [5:0] ADDR_RAMP_POS = 6'h02;
	localparam logic [5:0] ADDR_ENC_POS = 6'h03;
	localparam logic [5:0] ADDR_DEVIATION = 6'h04;
	localparam logic [5:0] ADDR_OFFSET = 6'h05;
	localparam logic [5:0] ADDR_MAX_ANGLE = 6'h06;
	localparam logic [5:0] ADDR_CTRL_TOL = 6'h07;
	localparam logic [5:0] ADDR_PGAIN = 6'h08;
	localparam logic [5:0] ADDR_FAIL_LIMIT = 6'h09;
	localparam logic [5:0] ADDR_VL_PGAIN = 6'h0A;
	localparam logic [5:0] ADDR_VL_IGAIN = 6'h0B;
	localparam logic [5:0] ADDR_DV_CLIP = 6'h0C;
	localparam logic [5:0] ADDR_I_CLIP = 6'h0D;
	localparam logic [5:0] ADDR_ISUM = 6'h0E;
	localparam logic [5:0] ADDR_SCALE_LIM = 6'h0F;
	localparam logic [5:0] ADDR_SCALE_THR = 6'h10;
	localparam logic [5:0] ADDR_SCALE_DLY = 6'h11;
	localparam logic [5:0] ADDR_EMF_ANGLE = 6'h12;
	localparam logic [5:0] ADDR_EMF_VSTART = 6'h13;
	localparam logic [5:0] ADDR_EMF_VSPAN = 6'h14;
	localparam logic [5:0] ADDR_FILT_VEL = 6'h15;
	localparam logic [5:0] ADDR_FILT_CFG = 6'h16;
	localparam logic [5:0] ADDR_ANGLE = 6'h17;
	localparam logic [5:0] ADDR_VEL_LIMIT = 6'h18;

	// Control register bit positions.
	localparam int CTL_MODE_LO = 0;
	localparam int CTL_CAL = 2;
	localparam int CTL_RESYNC = 3;
	localparam int CTL_VLIM = 4;
	localparam int CTL_SCALE = 5;
	localparam int CTL_EMF = 6;

	// Status bit positions; bits 4..6 are sticky events cleared by writing one.
	localparam int ST_FIT_F = 0;
	localparam int ST_FAIL_F = 1;
	localparam int ST_MAX_F = 2;
	localparam int ST_CAL_BUSY = 3;
	localparam int ST_EV_MAX = 4;
	localparam int ST_EV_FIT = 5;
	localparam int ST_EV_FAIL = 6;

	// Mode codes of the control mode selector.
	localparam logic [1:0] MODE_CLOSED = 2'h1;

	// Reset values.
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [23:0] RST_PGAIN = 24'h01_0000;
	localparam logic [7:0] RST_IMAX = 8'hFF;
	localparam logic [15:0] RST_FILT_WAIT = 16'h0020;

	// Fixed-point and timing figures.
	localparam int PGAIN_FRAC = 16;
	localparam int INTEG_DIV = 128;
	localparam int INTEG_CNT_W = 7;

	// Register bus request.
	typedef struct packed {
		logic [5:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} bus_req_t;

	// Register bus answer.
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} bus_rsp_t;

	// Driver-side output of the unit.
	typedef struct packed {
		logic [31:0] angle;
		logic [7:0] current_scale;
		logic [31:0] vel_limit;
		logic closed_loop;
	} drive_out_t;

endpackage

// ### closed_loop_stepper_control.sv
// Closed-loop commutation unit with Avalon-MM register access.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module closed_loop_stepper_control
	import cl_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Register bus.
	input wire bus_req_t bus_i,
	output bus_rsp_t bus_o,
	// Motion inputs from ramp generator and encoder unit (same clock).
	input wire logic [31:0] ramp_pos_i,
	input wire logic [31:0] enc_pos_i,
	input wire logic [31:0] enc_vel_i,
	input wire logic ramp_done_i,
	// Outputs toward driver and ramp generator.
	output drive_out_t drive_o,
	output logic ramp_load_o,
	output logic [31:0] ramp_load_val_o,
	output logic [7:0] status_o
);

	// Software registers.
	logic [6:0] ctrl_r; // Mode, calibrate, resync, limiter, scaling, emf enables.
	logic [31:0] offset_r; // Loop offset.
	logic [31:0] max_angle_r; // Maximum commutation angle.
	logic [19:0] ctol_r; // Controller tolerance.
	logic [23:0] pgain_r; // Proportional gain.
	logic [31:0] fail_lim_r; // Deviation fail limit.
	logic [15:0] vl_p_r; // Limiter P gain.
	logic [15:0] vl_i_r; // Limiter I gain.
	logic [31:0] dv_clip_r; // Velocity delta clip.
	logic [31:0] i_clip_r; // Integral clip.
	logic [15:0] scale_lim_r; // Max scale [15:8], min scale [7:0].
	logic [63:0] scale_thr_r; // Downscale [63:32], upscale [31:0].
	logic [31:0] scale_dly_r; // Downscale delay [31:16], upscale delay [15:0].
	logic [31:0] emf_angle_r; // Maximum extra load angle.
	logic [31:0] emf_vstart_r; // Start velocity.
	logic [31:0] emf_vspan_r; // Velocity span.
	logic [19:0] filt_cfg_r; // Filter exponent [19:16], period [15:0].
	logic [6:0] status_r; // Flags and sticky events.
	logic [31:0] isum_r; // Integral sum.
	logic [31:0] fvel_r; // Filtered encoder velocity.
	logic [7:0] scale_r; // Current scale.
	logic [31:0] angle_r; // Commutation angle.
	logic [31:0] vlim_r; // Correction velocity ceiling.
	logic [31:0] dev_r; // Registered deviation.
	logic cal_pend_r; // Calibration pending.
	logic [1:0] mode_q_r; // Mode of last cycle, to see entry.
	logic [INTEG_CNT_W-1:0] integ_cnt_r; // Integral step divider.
	logic [15:0] filt_cnt_r; // Filter period counter.
	logic [15:0] sdly_cnt_r; // Scale step delay counter.
	logic [31:0] rdata_r; // Read data hold.
	logic rd_ack_r; // One-cycle read wait done.

	// Combinational terms.
	logic [31:0] dev; // Signed deviation.
	logic [31:0] adev; // Absolute deviation.
	logic [7:0] tol; // Deviation tolerance.
	logic in_tol; // Deviation within tolerance.
	logic over_max; // Deviation above maximum angle.
	logic over_fail; // Deviation beyond fail limit.
	logic [55:0] prod; // Gain times absolute deviation.
	logic [31:0] corr; // Clipped correction magnitude.
	logic [31:0] emf_add; // Extra load angle magnitude.
	logic [31:0] down_start; // Effective downscale start.
	logic [7:0] scale_tgt; // Target scale for this deviation.
	logic closed; // Closed-loop mode selected.
	logic integ_tick; // Integral time step.
	logic wr; // Register write accepted this cycle.

	assign closed = ctrl_r[1:0] == MODE_CLOSED;
	assign dev = ramp_pos_i - enc_pos_i;
	assign adev = dev[31] ? (32'h0000_0000 - dev) : dev;
	assign tol = ctol_r[7:0];
	assign in_tol = adev < {24'h00_0000, tol};
	assign over_max = adev > max_angle_r;
	assign over_fail = adev > fail_lim_r;
	assign integ_tick = integ_cnt_r == INTEG_CNT_W'(INTEG_DIV - 1);
	assign wr = bus_i.write;

	// Outside the band the gain applies (16 fraction bits), inside it the factor is one.
	always_comb
	begin
		prod = {24'h00_0000, adev} * {32'h0000_0000, pgain_r};
		if (adev <= {24'h00_0000, tol})
		begin
			corr = adev;
		end
		else if (prod[55:PGAIN_FRAC+32] != '0)
		begin
			// A product too wide for one word lies beyond any angle; clip before truncating.
			corr = max_angle_r;
		end
		else
		begin
			corr = prod[PGAIN_FRAC+31:PGAIN_FRAC];
		end
		if (corr > max_angle_r)
		begin
			corr = max_angle_r;
		end
	end

	// Extra load angle rises linearly with velocity above the start point and saturates.
	always_comb
	begin
		logic [31:0] avel;
		logic [31:0] above;
		logic [63:0] ramp_mul;
		// Speed in either direction counts; the sign is applied at the angle.
		avel = fvel_r[31] ? (32'h0000_0000 - fvel_r) : fvel_r;
		above = avel - emf_vstart_r;
		ramp_mul = {32'h0000_0000, above} * {32'h0000_0000, emf_angle_r};
		if (!ctrl_r[CTL_EMF] || avel <= emf_vstart_r)
		begin
			emf_add = 32'h0000_0000;
		end
		else if (above >= emf_vspan_r)
		begin
			emf_add = emf_angle_r;
		end
		else
		begin
			emf_add = 32'(ramp_mul / {32'h0000_0000, emf_vspan_r});
		end
	end

	// Scale target follows the deviation, with hysteresis on the way down.
	always_comb
	begin
		logic [63:0] lin;
		logic [7:0] span;
		logic [31:0] start;
		down_start = (scale_thr_r[63:32] == 32'h0000_0000) ? max_angle_r : scale_thr_r[63:32];
		start = (scale_r > scale_lim_r[7:0]) ? down_start : scale_thr_r[31:0];
		span = scale_lim_r[15:8] - scale_lim_r[7:0];
		lin = 64'h0;
		if (adev <= start)
		begin
			scale_tgt = scale_lim_r[7:0];
		end
		else if (adev >= max_angle_r || max_angle_r <= start)
		begin
			scale_tgt = scale_lim_r[15:8];
		end
		else
		begin
			lin = {32'h0000_0000, adev - start} * {56'h0, span};
			scale_tgt = scale_lim_r[7:0] + 8'(lin / {32'h0000_0000, max_angle_r - start});
		end
	end

	// Avalon slave: writes take effect at once; reads wait one cycle for the mux.
	assign bus_o.waitrequest = bus_i.read && !rd_ack_r;
	assign bus_o.readdata = rdata_r;

	always_ff @(posedge clk_i)
	begin
		if (srst_i || rd_ack_r)
		begin
			rd_ack_r <= 1'b0;
		end
		else
		begin
			rd_ack_r <= bus_i.read;
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			rdata_r <= RST_ZERO;
		end
		else
		begin
			unique case (bus_i.address)
				ADDR_CONTROL: rdata_r <= {25'h0, ctrl_r};
				ADDR_STATUS: rdata_r <= {25'h0, status_r};
				ADDR_RAMP_POS: rdata_r <= ramp_pos_i;
				ADDR_ENC_POS: rdata_r <= enc_pos_i;
				ADDR_DEVIATION: rdata_r <= dev_r;
				ADDR_OFFSET: rdata_r <= offset_r;
				ADDR_MAX_ANGLE: rdata_r <= max_angle_r;
				ADDR_CTRL_TOL: rdata_r <= {12'h000, ctol_r};
				ADDR_PGAIN: rdata_r <= {8'h00, pgain_r};
				ADDR_FAIL_LIMIT: rdata_r <= fail_lim_r;
				ADDR_VL_PGAIN: rdata_r <= {16'h0000, vl_p_r};
				ADDR_VL_IGAIN: rdata_r <= {16'h0000, vl_i_r};
				ADDR_DV_CLIP: rdata_r <= dv_clip_r;
				ADDR_I_CLIP: rdata_r <= i_clip_r;
				ADDR_ISUM: rdata_r <= isum_r;
				ADDR_SCALE_LIM: rdata_r <= {16'h0000, scale_lim_r};
				ADDR_SCALE_THR: rdata_r <= scale_thr_r[31:0];
				ADDR_SCALE_DLY: rdata_r <= scale_dly_r;
				ADDR_EMF_ANGLE: rdata_r <= emf_angle_r;
				ADDR_EMF_VSTART: rdata_r <= emf_vstart_r;
				ADDR_EMF_VSPAN: rdata_r <= emf_vspan_r;
				ADDR_FILT_VEL: rdata_r <= fvel_r;
				ADDR_FILT_CFG: rdata_r <= {12'h000, filt_cfg_r};
				ADDR_ANGLE: rdata_r <= angle_r;
				ADDR_VEL_LIMIT: rdata_r <= vlim_r;
				default: rdata_r <= RST_ZERO;
			endcase
		end
	end

	// Configuration registers. The downscale threshold is written at the integral sum's
	// address ADDR_ISUM, whose read returns the integral sum, so one word holds each threshold.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ctrl_r <= 7'h00;
			max_angle_r <= RST_ZERO;
			ctol_r <= 20'h0_0000;
			pgain_r <= RST_PGAIN;
			fail_lim_r <= 32'hFFFF_FFFF;
			vl_p_r <= 16'h0000;
			vl_i_r <= 16'h0000;
			dv_clip_r <= RST_ZERO;
			i_clip_r <= RST_ZERO;
			scale_lim_r <= {RST_IMAX, 8'h00};
			scale_thr_r <= 64'h0;
			scale_dly_r <= RST_ZERO;
			emf_angle_r <= RST_ZERO;
			emf_vstart_r <= RST_ZERO;
			emf_vspan_r <= RST_ZERO;
			filt_cfg_r <= {4'h4, RST_FILT_WAIT};
		end
		else if (wr)
		begin
			unique case (bus_i.address)
				ADDR_CONTROL: ctrl_r <= bus_i.writedata[6:0];
				ADDR_MAX_ANGLE: max_angle_r <= bus_i.writedata;
				ADDR_CTRL_TOL: ctol_r <= bus_i.writedata[19:0];
				ADDR_PGAIN: pgain_r <= bus_i.writedata[23:0];
				ADDR_FAIL_LIMIT: fail_lim_r <= bus_i.writedata;
				ADDR_VL_PGAIN: vl_p_r <= bus_i.writedata[15:0];
				ADDR_VL_IGAIN: vl_i_r <= bus_i.writedata[15:0];
				ADDR_DV_CLIP: dv_clip_r <= bus_i.writedata;
				ADDR_I_CLIP: i_clip_r <= bus_i.writedata;
				ADDR_SCALE_LIM: scale_lim_r <= bus_i.writedata[15:0];
				ADDR_SCALE_THR: scale_thr_r[31:0] <= bus_i.writedata;
				ADDR_STATUS: scale_thr_r[63:32] <= scale_thr_r[63:32];
				ADDR_SCALE_DLY: scale_dly_r <= bus_i.writedata;
				ADDR_EMF_ANGLE: emf_angle_r <= bus_i.writedata;
				ADDR_EMF_VSTART: emf_vstart_r <= bus_i.writedata;
				ADDR_EMF_VSPAN: emf_vspan_r <= bus_i.writedata;
				ADDR_FILT_CFG: filt_cfg_r <= bus_i.writedata[19:0];
				ADDR_ISUM: scale_thr_r[63:32] <= bus_i.writedata;
				default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	// Loop offset: a write fixes a tested value; calibration captures the deviation.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			offset_r <= RST_ZERO;
			cal_pend_r <= 1'b0;
			mode_q_r <= 2'h0;
		end
		else
		begin
			mode_q_r <= ctrl_r[1:0];
			if (cal_pend_r)
			begin
				offset_r <= dev;
				cal_pend_r <= 1'b0;
			end
			else if (wr && bus_i.address == ADDR_OFFSET)
			begin
				offset_r <= bus_i.writedata;
			end
			if ((closed && mode_q_r != MODE_CLOSED) || ctrl_r[CTL_CAL])
			begin
				cal_pend_r <= 1'b1;
			end
		end
	end

	// Status flags and sticky events; a set in the clearing cycle wins.
	always_ff @(posedge clk_i)
	begin
		logic [6:0] clr;
		clr = (wr && bus_i.address == ADDR_STATUS) ? bus_i.writedata[6:0] : 7'h00;
		if (srst_i)
		begin
			status_r <= 7'h00;
			dev_r <= RST_ZERO;
		end
		else
		begin
			dev_r <= dev;
			status_r[ST_FIT_F] <= in_tol;
			status_r[ST_MAX_F] <= over_max;
			status_r[ST_CAL_BUSY] <= cal_pend_r;
			status_r[ST_FAIL_F] <= over_fail | (status_r[ST_FAIL_F] & ~clr[ST_FAIL_F]);
			status_r[ST_EV_MAX] <= (over_max & ~status_r[ST_MAX_F])
				| (status_r[ST_EV_MAX] & ~clr[ST_EV_MAX]);
			status_r[ST_EV_FIT] <= (in_tol & ~status_r[ST_FIT_F])
				| (status_r[ST_EV_FIT] & ~clr[ST_EV_FIT]);
			status_r[ST_EV_FAIL] <= (over_fail & ~status_r[ST_FAIL_F])
				| (status_r[ST_EV_FAIL] & ~clr[ST_EV_FAIL]);
		end
	end

	// Commutation angle: encoder position plus clipped correction, offset and back-EMF.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			angle_r <= RST_ZERO;
		end
		else
		begin
			// Correction follows the deviation's sign, extra load angle the direction of motion.
			angle_r <= enc_pos_i + offset_r + (dev[31] ? (32'h0000_0000 - corr) : corr)
				+ (fvel_r[31] ? (32'h0000_0000 - emf_add) : emf_add);
		end
	end

	// Integral divider and PI velocity limiter on the fixed integral time step.
	always_ff @(posedge clk_i)
	begin
		logic [63:0] isum_n;
		logic [63:0] pi;
		isum_n = {32'h0, isum_r} + {32'h0, adev} * {48'h0, vl_i_r};
		if (isum_n > {32'h0, i_clip_r})
		begin
			isum_n = {32'h0, i_clip_r};
		end
		pi = {32'h0, adev} * {48'h0, vl_p_r} + isum_n;
		if (pi > {32'h0, dv_clip_r})
		begin
			pi = {32'h0, dv_clip_r};
		end
		if (srst_i)
		begin
			integ_cnt_r <= '0;
			isum_r <= RST_ZERO;
			vlim_r <= RST_ZERO;
		end
		else
		begin
			integ_cnt_r <= integ_cnt_r + 1'b1;
			if (!ctrl_r[CTL_VLIM] || in_tol || dv_clip_r == 32'h0 || vl_p_r == 16'h0
				|| vl_i_r == 16'h0)
			begin
				isum_r <= RST_ZERO;
				vlim_r <= RST_ZERO;
			end
			else if (integ_tick)
			begin
				isum_r <= isum_n[31:0];
				vlim_r <= pi[31:0];
			end
			else if (vlim_r > dv_clip_r)
			begin
				// A lowered clip applies at once, not only at the next integral step.
				vlim_r <= dv_clip_r;
			end
		end
	end

	// Exponential velocity filter, updated once every programmed period plus one cycles.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			filt_cnt_r <= 16'h0000;
			fvel_r <= RST_ZERO;
		end
		else if (filt_cnt_r >= filt_cfg_r[15:0])
		begin
			filt_cnt_r <= 16'h0000;
			// Arithmetic shifts keep a reverse velocity negative through the filter.
			fvel_r <= fvel_r - 32'($signed(fvel_r) >>> filt_cfg_r[19:16])
				+ 32'($signed(enc_vel_i) >>> filt_cfg_r[19:16]);
		end
		else
		begin
			filt_cnt_r <= filt_cnt_r + 16'h0001;
		end
	end

	// Current scale: one step toward the target after each elapsed delay.
	always_ff @(posedge clk_i)
	begin
		logic [15:0] dly;
		dly = (scale_tgt > scale_r) ? scale_dly_r[15:0] : scale_dly_r[31:16];
		if (srst_i)
		begin
			scale_r <= RST_IMAX;
			sdly_cnt_r <= 16'h0000;
		end
		else if (scale_tgt == scale_r)
		begin
			sdly_cnt_r <= 16'h0000;
		end
		else if (sdly_cnt_r >= dly)
		begin
			sdly_cnt_r <= 16'h0000;
			scale_r <= (scale_tgt > scale_r) ? scale_r + 8'h01 : scale_r - 8'h01;
		end
		else
		begin
			sdly_cnt_r <= sdly_cnt_r + 16'h0001;
		end
	end

	// Driver outputs; loop scaling replaces the fixed maximum scale when enabled in closed-loop mode.
	assign drive_o.angle = angle_r;
	assign drive_o.current_scale = (closed && ctrl_r[CTL_SCALE]) ? scale_r : RST_IMAX;
	assign drive_o.vel_limit = vlim_r;
	assign drive_o.closed_loop = closed;
	assign status_o = {1'b0, status_r};
	// Resync is asked for in every cycle beyond the limit; the reload itself removes the cause.
	assign ramp_load_o = closed && ctrl_r[CTL_RESYNC] && over_fail;
	assign ramp_load_val_o = enc_pos_i;

	// Deviation register tracks ramp minus encoder one cycle later.
	a_dev_track: assert property (@(posedge clk_i) disable iff (srst_i)
		##1 dev_r == $past(ramp_pos_i) - $past(enc_pos_i)) else $error("deviation wrong");
	// Correction never exceeds the maximum angle.
	a_corr_clip: assert property (@(posedge clk_i) disable iff (srst_i)
		corr <= max_angle_r) else $error("angle not clipped");
	// Fit flag follows the tolerance test.
	a_fit_flag: assert property (@(posedge clk_i) disable iff (srst_i)
		in_tol |=> status_r[ST_FIT_F]) else $error("fit flag missing");
	// Fit event fires on entry into tolerance.
	a_fit_event: assert property (@(posedge clk_i) disable iff (srst_i)
		(in_tol && !status_r[ST_FIT_F]) |=> status_r[ST_EV_FIT]) else $error("fit event lost");
	// Unit factor inside tolerance.
	a_unit_gain: assert property (@(posedge clk_i) disable iff (srst_i)
		(in_tol && adev <= max_angle_r) |-> corr == adev) else $error("gain not one");
	// Fail event fires and persists beyond the fail limit.
	a_fail_event: assert property (@(posedge clk_i) disable iff (srst_i)
		over_fail |=> status_r[ST_FAIL_F] && status_r[ST_EV_FAIL]) else $error("fail lost");
	// Limiter output stays within the delta clip except in the cycle in which the clip changes.
	a_vlim_clip: assert property (@(posedge clk_i) disable iff (srst_i)
		vlim_r <= dv_clip_r || $changed(dv_clip_r)) else $error("limit exceeds clip");
	// Integral sum is at or below its clip after each integral step.
	a_isum_clip: assert property (@(posedge clk_i) disable iff (srst_i)
		integ_tick |=> isum_r <= i_clip_r) else $error("integral not clamped");
	// No further integral step comes in the 8 cycles after one.
	a_integ_rate: assert property (@(posedge clk_i) disable iff (srst_i)
		integ_tick |=> !integ_tick [*8]) else $error("integral rate wrong");
	// Integral steps are exactly 128 cycles apart.
	a_integ_period: assert property (@(posedge clk_i) disable iff (srst_i)
		integ_tick |-> ##128 integ_tick) else $error("integral period wrong");

endmodule // closed_loop_stepper_control

// ### closed_loop_stepper_control_test.sv
// Self-checking testbench of the closed-loop commutation unit.
`timescale 1ns/1ns
module closed_loop_stepper_control_test import cl_pkg::*;;
	localparam int TOL = 8; // Deviation tolerance used throughout.
	localparam int MAXA = 1000; // Maximum commutation angle used throughout.
	localparam logic [31:0] GAIN = 32'h0002_0000; // Gain of exactly two.
	localparam int VS = 100; // Back-EMF start velocity.
	localparam int VSPAN = 200; // Back-EMF velocity span.
	localparam int GMAX = 50; // Maximum extra load angle.
	// Clock, reset and bus.
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	bus_req_t bus_i = '0;
	bus_rsp_t bus_o;
	// Motion signals between model and unit.
	logic [31:0] ramp_pos_i, enc_pos_i, enc_vel_i, ramp_load_val_o;
	logic ramp_done_i = 1'b0;
	logic ramp_load_o;
	drive_out_t drive_o;
	logic [7:0] status_o, load_count;
	// Bench requests to the model.
	logic set_req = 1'b0;
	logic [31:0] ramp_set = '0, enc_set = '0, vel_set = '0;
	int n_errors = 0;
	int checked = 0;
	logic [31:0] d, enc;
	int devs[6] = '{10, 1, -10, 5000, -3, 8};
	int vels[4] = '{200, -400, 150, 100};

	// Free-running system clock.
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	closed_loop_stepper_control dut (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus_i),
		.bus_o(bus_o), .ramp_pos_i(ramp_pos_i), .enc_pos_i(enc_pos_i), .enc_vel_i(enc_vel_i),
		.ramp_done_i(ramp_done_i), .drive_o(drive_o), .ramp_load_o(ramp_load_o),
		.ramp_load_val_o(ramp_load_val_o), .status_o(status_o));

	motion_source_model partner (.clk_i(clk_i), .srst_i(srst_i), .set_i(set_req),
		.ramp_set_i(ramp_set), .enc_set_i(enc_set), .vel_set_i(vel_set),
		.ramp_load_i(ramp_load_o), .ramp_load_val_i(ramp_load_val_o),
		.ramp_pos_o(ramp_pos_i), .enc_pos_o(enc_pos_i), .enc_vel_o(enc_vel_i),
		.load_count_o(load_count));

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One bus access; the request is held until waitrequest is sampled low at a rising edge.
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		bus_i <= '{address: a, read: !w, write: w, writedata: wd};
		do
			@(posedge clk_i);
		while (bus_o.waitrequest !== 1'b0);
		rdv = bus_o.readdata;
		bus_i <= '0;
		@(posedge clk_i);
	endtask

	// Register write.
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		logic [31:0] dummy;
		acc(1'b1, a, v, dummy);
	endtask

	// Register read compared with an expected value.
	task automatic rdc(input string name, input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] v;
		acc(1'b0, a, 32'h0000_0000, v);
		chk(name, exp, v);
	endtask

	// Moves ramp and encoder positions, then lets the unit settle.
	task automatic pos(input logic [31:0] r, input logic [31:0] e);
		ramp_set <= r;
		enc_set <= e;
		set_req <= 1'b1;
		@(posedge clk_i);
		set_req <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask

	// Expected angle with zero offset: unit factor inside tolerance, clipped gain outside.
	function automatic logic [31:0] exp_angle(input logic [31:0] e, input int dv);
		longint mag;
		mag = (dv < 0) ? -dv : dv;
		if (mag > TOL)
			mag = mag * (GAIN >> PGAIN_FRAC);
		if (mag > MAXA)
			mag = MAXA;
		return (dv < 0) ? e - 32'(mag) : e + 32'(mag);
	endfunction

	// Expected extra load angle for a filtered velocity, signed by the direction of motion.
	function automatic logic [31:0] exp_emf(input int v);
		int a;
		a = (v < 0) ? -v : v;
		if (a <= VS)
			a = 0;
		else if (a - VS >= VSPAN)
			a = GMAX;
		else
			a = (a - VS) * GMAX / VSPAN;
		return (v < 0) ? -a : a;
	endfunction

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("errors %0d comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog cuts a hang short well beyond the expected run length.
	initial
	begin
		#200000;
		n_errors++;
		results();
	end

	// Main sequence.
	initial
	begin
		d = $urandom(77777);
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk("scale_rst", 32'h0000_00FF, {24'h0, drive_o.current_scale});
		rdc("pgain_rst", ADDR_PGAIN, {8'h00, RST_PGAIN});
		rdc("fail_rst", ADDR_FAIL_LIMIT, 32'hFFFF_FFFF);
		rdc("scale_lim_rst", ADDR_SCALE_LIM, 32'h0000_FF00);
		rdc("filt_rst", ADDR_FILT_CFG, 32'h0004_0020);
		rdc("unmapped", 6'h3F, 32'h0000_0000);
		wr(ADDR_CTRL_TOL, 32'hFFFF_FFFF);
		rdc("tol_width", ADDR_CTRL_TOL, 32'h000F_FFFF);
		wr(ADDR_PGAIN, 32'hFFFF_FFFF);
		rdc("gain_width", ADDR_PGAIN, 32'h00FF_FFFF);
		// Random positions, deviation is their difference.
		for (int i = 0; i < 8; i++)
		begin
			d = $urandom;
			enc = $urandom;
			pos(d, enc);
			rdc("deviation", ADDR_DEVIATION, d - enc);
		end
		// Calibration at standstill on a full-step position.
		enc = $urandom & 32'h000F_FF00;
		pos(enc + 32'd100, enc);
		wr(ADDR_CONTROL, 32'h0000_0001);
		repeat (4) @(posedge clk_i);
		rdc("offset_entry", ADDR_OFFSET, 32'd100);
		chk("closed_loop", 32'h1, {31'h0, drive_o.closed_loop});
		pos(enc + 32'd50, enc);
		wr(ADDR_CONTROL, 32'h0000_0005);
		repeat (4) @(posedge clk_i);
		rdc("offset_cal", ADDR_OFFSET, 32'd50);
		wr(ADDR_CONTROL, 32'h0000_0001);
		wr(ADDR_OFFSET, 32'h0000_0000);
		rdc("offset_write", ADDR_OFFSET, 32'h0000_0000);
		// Angle, tolerance and limit events over a table of deviations.
		wr(ADDR_CTRL_TOL, TOL);
		wr(ADDR_PGAIN, GAIN);
		wr(ADDR_MAX_ANGLE, MAXA);
		wr(ADDR_STATUS, 32'h0000_0070);
		foreach (devs[i])
		begin
			pos(enc + devs[i], enc);
			chk("angle", exp_angle(enc, devs[i]), drive_o.angle);
			chk("fit_flag", (devs[i] < TOL && devs[i] > -TOL), status_o[ST_FIT_F]);
		end
		chk("fit_event", 32'h1, {31'h0, status_o[ST_EV_FIT]});
		chk("max_event", 32'h1, {31'h0, status_o[ST_EV_MAX]});
		// Deviation beyond the fail limit with resync enabled.
		wr(ADDR_FAIL_LIMIT, 32'd2000);
		wr(ADDR_CONTROL, 32'h0000_0009);
		pos(enc + 32'd3000, enc);
		chk("resync_count", 32'h1, {24'h0, load_count});
		chk("resync_pos", enc, ramp_pos_i);
		chk("fail_event", 32'h1, {31'h0, status_o[ST_EV_FAIL]});
		// Loop current scaling between minimum and maximum.
		wr(ADDR_SCALE_LIM, 32'h0000_8010);
		wr(ADDR_SCALE_THR, 32'd100);
		wr(ADDR_ISUM, 32'h0000_0000);
		wr(ADDR_SCALE_DLY, 32'h0000_0000);
		wr(ADDR_CONTROL, 32'h0000_0021);
		pos(enc, enc);
		repeat (600) @(posedge clk_i);
		chk("scale_min", 32'h10, {24'h0, drive_o.current_scale});
		pos(enc + 32'd5000, enc);
		repeat (600) @(posedge clk_i);
		chk("scale_max", 32'h80, {24'h0, drive_o.current_scale});
		pos(enc, enc);
		repeat (600) @(posedge clk_i);
		chk("scale_down", 32'h10, {24'h0, drive_o.current_scale});
		wr(ADDR_CONTROL, 32'h0000_0001);
		chk("scale_off", 32'hFF, {24'h0, drive_o.current_scale});
		// Velocity limiter: proportional plus clamped integral, then delta clip and gain gate.
		wr(ADDR_VL_PGAIN, 32'h1);
		wr(ADDR_VL_IGAIN, 32'h1);
		wr(ADDR_I_CLIP, 32'd100);
		wr(ADDR_DV_CLIP, 32'd1000);
		wr(ADDR_CONTROL, 32'h0000_0011);
		pos(enc + 32'd20, enc);
		repeat (1000) @(posedge clk_i);
		chk("vel_limit", 32'd20 + 32'd100, drive_o.vel_limit);
		rdc("isum", ADDR_ISUM, 32'd100);
		wr(ADDR_DV_CLIP, 32'd50);
		@(posedge clk_i);
		chk("vel_clip", 32'd50, drive_o.vel_limit);
		wr(ADDR_VL_IGAIN, 32'h0);
		@(posedge clk_i);
		chk("vel_gate", 32'h0, drive_o.vel_limit);
		// Back-EMF extra angle with zero deviation and a filter exponent of zero.
		wr(ADDR_FILT_CFG, 32'h0000_0020);
		wr(ADDR_EMF_ANGLE, GMAX);
		wr(ADDR_EMF_VSTART, VS);
		wr(ADDR_EMF_VSPAN, VSPAN);
		wr(ADDR_CONTROL, 32'h0000_0041);
		vels[3] = int'($urandom % 32'd1400) - 700;
		foreach (vels[i])
		begin
			vel_set <= vels[i];
			pos(enc, enc);
			repeat (40) @(posedge clk_i);
			rdc("filt_vel", ADDR_FILT_VEL, vels[i]);
			chk("emf_angle", enc + exp_emf(vels[i]), drive_o.angle);
		end
		results();
	end
endmodule // closed_loop_stepper_control_test

// ### motion_source_model.sv
// Behavioural ramp generator and position encoder that feed the closed-loop unit.
`timescale 1ns/1ns
module motion_source_model
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Values requested by the bench.
	input wire logic set_i,
	input wire logic [31:0] ramp_set_i,
	input wire logic [31:0] enc_set_i,
	input wire logic [31:0] vel_set_i,
	// Resync request from the unit.
	input wire logic ramp_load_i,
	input wire logic [31:0] ramp_load_val_i,
	// Values toward the unit.
	output logic [31:0] ramp_pos_o,
	output logic [31:0] enc_pos_o,
	output logic [31:0] enc_vel_o,
	output logic [7:0] load_count_o
);
	// Ramp position; a resync wins over the bench, as the real ramp generator obeys it.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			ramp_pos_o <= 32'h0000_0000;
		else if (ramp_load_i)
			ramp_pos_o <= ramp_load_val_i;
		else if (set_i)
			ramp_pos_o <= ramp_set_i;
	end

	// Encoder position and velocity change only when the bench asks.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			enc_pos_o <= 32'h0000_0000;
			enc_vel_o <= 32'h0000_0000;
		end
		else if (set_i)
		begin
			enc_pos_o <= enc_set_i;
			enc_vel_o <= vel_set_i;
		end
	end

	// Resync pulses are counted so that a one-cycle pulse is never missed.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			load_count_o <= 8'h00;
		else if (ramp_load_i)
			load_count_o <= load_count_o + 8'h01;
	end
endmodule // motion_source_model
